// file: include/ddr_input_capture_regs.vh
`ifndef DDR_INPUT_CAPTURE_REGS_VH
`define DDR_INPUT_CAPTURE_REGS_VH

// register byte offsets
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4

// control field positions
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_DELAY_EN 2
`define CTRL_DELAY_DYN 3
`define CTRL_DYN_SEL_LO 4
`define CTRL_DYN_SEL_HI 7
`define CTRL_CE 8
`define CTRL_LSR 9
`define CTRL_CLK_POL 10
`define CTRL_SDR_TRI 11
`define CTRL_DDR_TRI_RISE 12
`define CTRL_DDR_TRI_FALL 13
`define CTRL_PAD_OUT 14
`define CTRL_WIDTH 15

// control reset value: bypass mode, clock enable on, pad tristated
`define CTRL_RESET 15'h0900

// capture modes
`define MODE_BYPASS 2'h0
`define MODE_SDR 2'h1
`define MODE_DDR 2'h2
`define MODE_GEAR 2'h3

// delay and strobe timing counts in system clock cycles
`define FIXED_DELAY_TAPS 4'h4
`define DATA_DELAY_DEPTH 16
`define STROBE_DELAY_DEPTH 64
`define STROBE_IDLE_CYCLES 5'h10

// cell placement codes
`define EDGE_LEFT 2'h0
`define EDGE_RIGHT 2'h1
`define EDGE_BOTTOM 2'h2
`define EDGE_TOP 2'h3

`endif

// file: design/sync_two_flop.v
`timescale 1ns/1ps
module sync_two_flop #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sync_two_flop

// file: design/ddr_input_capture.v
// How it works
// [RL1] pad data may bypass delay and registers, reaching core as plain data or clock; here both outputs pass the pin synchroniser and one register
// [RL2] optional input delay is fixed or picked at run time by four-bit select
// [RL3] single-rate mode captures input with the system clock in one register
// [RL4] double-rate mode samples data on strobe rising and falling edges, two streams
// [RL5] both strobe streams are re-timed to the system clock before the core
// [RL6] gearbox mode splits one double-rate input into four parallel core streams
// [RL7] registered single-rate input is taken on the primary clock rising edge
// [RL8] global set/reset is active low, holding registers reset while low
// [RL9] polarity control selects primary clock polarity for double-rate capture
// [RL10] polarity logic derived from the strobe sets sync register clock polarity
// [RL11] strobe delay is trimmed by a six-bit calibration bus from a DLL
// [RL12] each DLL trims only strobe delays in its own half of the device
// [RL13] single-rate output enable follows one tristate control from the core
// [RL14] double-rate output enable comes from a register stage with two controls
// [RL15] input and output registers update only while clock enable is high
// [RL16] gearbox pipelined outputs exist only on left, right and bottom cells
// [RL17] first double-rate stream holds the rising sample, second the falling
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "ddr_input_capture_regs.vh"
module ddr_input_capture #(
  parameter [1:0] CELL_EDGE = 2'h0,
  parameter UPPER_HALF = 0
) (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire PAD_DATA_IN,
  input wire STROBE_IN,
  input wire GLOBAL_SET_RESET_N,
  input wire [5:0] DLL_CAL_LOWER,
  input wire [5:0] DLL_CAL_UPPER,
  output reg PAD_DATA_OUT,
  output reg PAD_OE_N,
  output reg UNREGISTERED_IN,
  output reg PAD_CLOCK_OUT,
  output reg SDR_REGISTERED_IN,
  output reg RISE_STREAM,
  output reg FALL_STREAM,
  output reg GEAR_OUT_A0,
  output reg GEAR_OUT_A1,
  output reg GEAR_OUT_B0,
  output reg GEAR_OUT_B1,
  output reg GEAR_PIPE_RISE0,
  output reg GEAR_PIPE_FALL0
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [2:0] pins_s;
  wire pad_s;
  wire strobe_s;
  wire gsr_n_s;

  sync_two_flop #(
    .WIDTH(3),
    .INIT(3'h4)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .async_in({GLOBAL_SET_RESET_N, STROBE_IN, PAD_DATA_IN}),
    .sync_out(pins_s)
  );

  assign pad_s = pins_s[0];
  assign strobe_s = pins_s[1];
  assign gsr_n_s = pins_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // control register and bus slave

  reg [`CTRL_WIDTH-1:0] ctrl_r;
  wire [1:0] mode;
  wire delay_en;
  wire delay_dyn;
  wire [3:0] dyn_delay_sel;
  wire ce;
  wire local_set_reset;
  wire capture_clk_polarity;
  wire sdr_tristate_ctl;
  wire ddr_tristate_rise;
  wire ddr_tristate_fall;
  wire req;
  wire hit_ctrl;
  wire hit_status;
  wire read_take;
  wire write_done;
  reg [31:0] status;
  reg [5:0] cal_code;
  reg strobe_pol_r;

  assign mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign delay_en = ctrl_r[`CTRL_DELAY_EN];
  assign delay_dyn = ctrl_r[`CTRL_DELAY_DYN];
  assign dyn_delay_sel = ctrl_r[`CTRL_DYN_SEL_HI:`CTRL_DYN_SEL_LO];
  assign ce = ctrl_r[`CTRL_CE];
  assign local_set_reset = ctrl_r[`CTRL_LSR];
  assign capture_clk_polarity = ctrl_r[`CTRL_CLK_POL];
  assign sdr_tristate_ctl = ctrl_r[`CTRL_SDR_TRI];
  assign ddr_tristate_rise = ctrl_r[`CTRL_DDR_TRI_RISE];
  assign ddr_tristate_fall = ctrl_r[`CTRL_DDR_TRI_FALL];

  assign req = AVS_READ | AVS_WRITE;
  assign hit_ctrl = (AVS_ADDRESS == `OFS_CTRL);
  assign hit_status = (AVS_ADDRESS == `OFS_STATUS);
  assign read_take = AVS_READ && AVS_WAITREQUEST;
  assign write_done = AVS_WRITE && !AVS_WAITREQUEST;

  always @* begin
    status = 32'h0;
    status[0] = SDR_REGISTERED_IN;
    status[1] = RISE_STREAM;
    status[2] = FALL_STREAM;
    status[3] = strobe_pol_r;
    status[9:4] = cal_code;
    status[10] = GEAR_OUT_A0;
    status[11] = GEAR_OUT_A1;
    status[12] = GEAR_OUT_B0;
    status[13] = GEAR_OUT_B1;
    status[14] = gsr_n_s;
  end

  // a write lands at the edge that completes it, waitrequest low
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r <= `CTRL_RESET;
    end else if (write_done && hit_ctrl) begin
      ctrl_r <= AVS_WRITEDATA[`CTRL_WIDTH-1:0];
    end
  end

  // one wait cycle, then the answer stands for one cycle
  // read data moves only for a read, so it holds across writes
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else if (req && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
      if (read_take && hit_ctrl) begin
        AVS_READDATA <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_r};
      end else if (read_take && hit_status) begin
        AVS_READDATA <= status;
      end else if (read_take) begin
        AVS_READDATA <= 32'h0;
      end
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass path and input delay

  reg [`DATA_DELAY_DEPTH-1:0] data_line_r;
  reg data_d;

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      UNREGISTERED_IN <= 1'b0;
      PAD_CLOCK_OUT <= 1'b0;
      data_line_r <= 16'h0;
    end else begin
      UNREGISTERED_IN <= pad_s; // RL1
      PAD_CLOCK_OUT <= pad_s; // RL1
      data_line_r <= {data_line_r[`DATA_DELAY_DEPTH-2:0], pad_s};
    end
  end

  always @* begin
    if (!delay_en) begin
      data_d = pad_s;
    end else if (delay_dyn) begin
      data_d = data_line_r[dyn_delay_sel]; // RL2
    end else begin
      data_d = data_line_r[`FIXED_DELAY_TAPS]; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe delay, calibration and polarity

  reg [`STROBE_DELAY_DEPTH-1:0] strobe_line_r;
  reg strobe_prev_r;
  reg [4:0] idle_cnt_r;
  wire strobe_d;
  wire strobe_rise;
  wire strobe_fall;
  wire strobe_edge;
  wire xfer_on_rise;

  always @* begin
    if (UPPER_HALF != 0) begin
      cal_code = DLL_CAL_UPPER; // RL12
    end else begin
      cal_code = DLL_CAL_LOWER; // RL12
    end
  end

  assign strobe_d = strobe_line_r[cal_code]; // RL11
  assign strobe_rise = strobe_d & ~strobe_prev_r;
  assign strobe_fall = ~strobe_d & strobe_prev_r;
  assign strobe_edge = strobe_rise | strobe_fall;
  assign xfer_on_rise = strobe_pol_r ^ capture_clk_polarity; // RL9

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      strobe_line_r <= 64'h0;
      strobe_prev_r <= 1'b0;
      idle_cnt_r <= `STROBE_IDLE_CYCLES;
      strobe_pol_r <= 1'b0;
    end else begin
      strobe_line_r <= {strobe_line_r[`STROBE_DELAY_DEPTH-2:0], strobe_s};
      strobe_prev_r <= strobe_d;
      if (strobe_edge) begin
        idle_cnt_r <= 5'h0;
        if (idle_cnt_r == `STROBE_IDLE_CYCLES) begin
          strobe_pol_r <= strobe_fall; // RL10
        end
      end else if (idle_cnt_r != `STROBE_IDLE_CYCLES) begin
        idle_cnt_r <= idle_cnt_r + 5'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture registers

  wire force_reset;
  wire gear_ok;
  wire ddr_mode;
  wire xfer;
  reg rise_q;
  reg fall_q;
  reg gear_phase_r;
  reg hold_rise_r;
  reg hold_fall_r;
  reg tri_phase_r;

  assign force_reset = ~gsr_n_s | local_set_reset; // RL8
  assign gear_ok = (CELL_EDGE != `EDGE_TOP); // RL16
  assign ddr_mode = (mode == `MODE_DDR) || (mode == `MODE_GEAR);
  assign xfer = xfer_on_rise ? strobe_rise : strobe_fall;

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      SDR_REGISTERED_IN <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      RISE_STREAM <= 1'b0;
      FALL_STREAM <= 1'b0;
      gear_phase_r <= 1'b0;
      hold_rise_r <= 1'b0;
      hold_fall_r <= 1'b0;
      GEAR_OUT_A0 <= 1'b0;
      GEAR_OUT_A1 <= 1'b0;
      GEAR_OUT_B0 <= 1'b0;
      GEAR_OUT_B1 <= 1'b0;
      GEAR_PIPE_RISE0 <= 1'b0;
      GEAR_PIPE_FALL0 <= 1'b0;
    end else if (force_reset) begin // RL8
      SDR_REGISTERED_IN <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      RISE_STREAM <= 1'b0;
      FALL_STREAM <= 1'b0;
      gear_phase_r <= 1'b0;
      hold_rise_r <= 1'b0;
      hold_fall_r <= 1'b0;
      GEAR_OUT_A0 <= 1'b0;
      GEAR_OUT_A1 <= 1'b0;
      GEAR_OUT_B0 <= 1'b0;
      GEAR_OUT_B1 <= 1'b0;
      GEAR_PIPE_RISE0 <= 1'b0;
      GEAR_PIPE_FALL0 <= 1'b0;
    end else if (ce) begin // RL15
      // leaving gear mode drops a half-built pair
      if (mode != `MODE_GEAR) begin
        gear_phase_r <= 1'b0;
      end
      if (mode == `MODE_SDR) begin
        SDR_REGISTERED_IN <= data_d; // RL3 RL7
      end
      if (ddr_mode && strobe_rise) begin
        rise_q <= data_d; // RL4
      end
      if (ddr_mode && strobe_fall) begin
        fall_q <= data_d; // RL4
      end
      if (ddr_mode && xfer) begin
        // pair re-timed together; the just-captured edge comes straight from data_d
        RISE_STREAM <= strobe_rise ? data_d : rise_q; // RL5 RL17
        FALL_STREAM <= strobe_fall ? data_d : fall_q; // RL5 RL17
      end
      if ((mode == `MODE_GEAR) && xfer && gear_ok) begin
        gear_phase_r <= ~gear_phase_r;
        if (!gear_phase_r) begin
          hold_rise_r <= strobe_rise ? data_d : rise_q;
          hold_fall_r <= strobe_fall ? data_d : fall_q;
        end else begin
          GEAR_OUT_A0 <= hold_rise_r; // RL6
          GEAR_OUT_A1 <= hold_fall_r; // RL6
          GEAR_OUT_B0 <= strobe_rise ? data_d : rise_q; // RL6
          GEAR_OUT_B1 <= strobe_fall ? data_d : fall_q; // RL6
        end
      end
      if ((mode == `MODE_GEAR) && gear_ok) begin
        GEAR_PIPE_RISE0 <= RISE_STREAM; // RL16
        GEAR_PIPE_FALL0 <= FALL_STREAM; // RL16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output and tristate register stage

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PAD_DATA_OUT <= 1'b0;
      PAD_OE_N <= 1'b1;
      tri_phase_r <= 1'b0;
    end else if (force_reset) begin
      PAD_DATA_OUT <= 1'b0;
      PAD_OE_N <= 1'b1;
      tri_phase_r <= 1'b0;
    end else if (ce) begin // RL15
      PAD_DATA_OUT <= ctrl_r[`CTRL_PAD_OUT];
      tri_phase_r <= ~tri_phase_r;
      if (ddr_mode) begin
        PAD_OE_N <= tri_phase_r ? ddr_tristate_fall : ddr_tristate_rise; // RL14
      end else begin
        PAD_OE_N <= sdr_tristate_ctl; // RL13
      end
    end
  end

endmodule // ddr_input_capture

// file: test/ddr_input_capture_monitor.sv
`timescale 1ns/1ps
module ddr_input_capture_monitor (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  input wire PAD_DATA_IN,
  input wire GLOBAL_SET_RESET_N,
  input wire PAD_OE_N,
  input wire UNREGISTERED_IN,
  input wire PAD_CLOCK_OUT,
  input wire SDR_REGISTERED_IN,
  input wire RISE_STREAM,
  input wire FALL_STREAM,
  input wire GEAR_PIPE_RISE0,
  input wire GEAR_PIPE_FALL0
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  sequence req_taken;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence gsr_held;
    !GLOBAL_SET_RESET_N [*4];
  endsequence
  a_req_answer: assert property (req_taken |=> !AVS_WAITREQUEST) else $error("bus request not answered");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low too long");
  a_rdata_holds: assert property (!$past(AVS_READ && AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
    else $error("read data moved");
  a_gsr_clears: assert property (gsr_held |=> !RISE_STREAM && !FALL_STREAM && !SDR_REGISTERED_IN)
    else $error("set/reset did not clear");
  a_gsr_oe: assert property (gsr_held |=> PAD_OE_N) else $error("pad driven in set/reset");
  a_bypass_path: assert property (UNREGISTERED_IN == $past(PAD_DATA_IN, 3)) else $error("bypass lag");
  a_clock_copy: assert property (PAD_CLOCK_OUT == UNREGISTERED_IN) else $error("clock out differs");
  a_pipe_rise: assert property ($rose(GEAR_PIPE_RISE0) |-> $past(RISE_STREAM)) else $error("pipe rise");
  a_pipe_fall: assert property ($rose(GEAR_PIPE_FALL0) |-> $past(FALL_STREAM)) else $error("pipe fall");
endmodule // ddr_input_capture_monitor

bind ddr_input_capture ddr_input_capture_monitor ddr_input_capture_monitor_inst (.*);

// file: test/strobe_source.sv
`timescale 1ns/1ps
module strobe_source (
  input wire clk,
  input wire go,
  input wire [3:0] bits,
  input wire lvl,
  output reg strobe = 1'b0,
  output reg data = 1'b0,
  output reg busy = 1'b0
);
  reg [4:0] k = 5'h0;
  // four bits, strobe edge centred, rise first, strobe still between bursts
  always @(posedge clk) begin
    if (busy) begin
      k <= k + 5'h1;
      if (k[1:0] == 2'h2)
        strobe <= ~strobe;
      if (k[1:0] == 2'h0 && k < 5'h10)
        data <= bits[k[3:2]];
      if (k == 5'h11) begin
        busy <= 1'b0;
        data <= lvl;
      end
    end else if (go) begin
      busy <= 1'b1;
      k <= 5'h1;
      data <= bits[0];
    end else
      data <= lvl;
  end
endmodule // strobe_source

// file: test/ddr_input_capture_bench.sv
`timescale 1ns/1ps
`include "ddr_input_capture_regs.vh"
module ddr_input_capture_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg gsr_n = 1'b1;
  reg [5:0] cal_lo = 6'h00;
  reg go = 1'b0;
  reg [3:0] bits = 4'h0;
  reg lvl = 1'b0;
  wire [31:0] rdat;
  wire wq, pin, stb, busy, oe_n, unreg, sdr, rise, fall, a0, a1, b0, b1, pr, pf, pdo;
  integer err_total = 0;
  integer n_compared = 0;
  integer ticks = 0;
  reg [31:0] q;
  ////////////////////////////////////////
  ddr_input_capture ddr_input_capture_inst (
    .CLK_SYS(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .PAD_DATA_IN(pin),
    .STROBE_IN(stb), .GLOBAL_SET_RESET_N(gsr_n), .DLL_CAL_LOWER(cal_lo), .DLL_CAL_UPPER(6'h3f),
    .PAD_DATA_OUT(pdo), .PAD_OE_N(oe_n), .UNREGISTERED_IN(unreg), .PAD_CLOCK_OUT(),
    .SDR_REGISTERED_IN(sdr), .RISE_STREAM(rise), .FALL_STREAM(fall), .GEAR_OUT_A0(a0),
    .GEAR_OUT_A1(a1), .GEAR_OUT_B0(b0), .GEAR_OUT_B1(b1), .GEAR_PIPE_RISE0(pr), .GEAR_PIPE_FALL0(pf));
  strobe_source strobe_source_inst (
    .clk(clk), .go(go), .bits(bits), .lvl(lvl), .strobe(stb), .data(pin), .busy(busy));
  ////////////////////////////////////////
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wq !== 1'b0)
        @(posedge clk);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      cyc(2);
    end
  endtask
  task burst(input [3:0] b);
    begin
      bits <= b;
      cyc(24);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy !== 1'b0)
        @(posedge clk);
      cyc(16);
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  task t_regs;
    begin
      bus(0, `OFS_CTRL, 0);
      chk("ctrl rst", q, `CTRL_RESET);
      bus(1, 4'h8, 32'hffffffff);
      bus(0, 4'h8, 0);
      chk("unmapped", q, 0);
      bus(1, `OFS_CTRL, 32'hffffffff);
      bus(0, `OFS_CTRL, 0);
      chk("ctrl rw", q, 32'h7fff);
      $display("regs end");
    end
  endtask
  task t_sdr;
    begin
      bus(1, `OFS_CTRL, 32'h0101);
      lvl <= 1'b1;
      cyc(6);
      chk("sdr in", sdr, 1);
      chk("oe on", oe_n, 0);
      bus(1, `OFS_CTRL, 32'h4901);
      chk("oe off", oe_n, 1);
      chk("pad out", pdo, 1);
      bus(1, `OFS_CTRL, 32'h0001);
      lvl <= 1'b0;
      cyc(6);
      chk("ce hold", sdr, 1);
      chk("pad hold", pdo, 1);
      chk("bypass", unreg, 0);
      $display("sdr end");
    end
  endtask
  task t_ddr;
    integer i;
    reg [3:0] b;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        b = i[0] ? 4'h9 : 4'h6;
        bus(1, `OFS_CTRL, {21'h0, i[1], 10'h102});
        burst(b);
        chk("rise", rise, b[2]);
        chk("fall", fall, i[1] ? b[1] : b[3]);
      end
      $display("ddr end");
    end
  endtask
  task t_delay;
    integer i;
    begin
      cal_lo <= 6'h04;
      for (i = 0; i < 2; i = i + 1) begin
        bus(1, `OFS_CTRL, i ? 32'h014e : 32'h0106);
        burst(4'h9);
        chk("dly rise", rise, 0);
        chk("dly fall", fall, 1);
      end
      bus(0, `OFS_STATUS, 0);
      chk("cal used", q[9:4], 4);
      chk("pol", q[3], 0);
      $display("delay end");
    end
  endtask
  task t_gear;
    begin
      bus(1, `OFS_CTRL, 32'h0307);
      bus(1, `OFS_CTRL, 32'h0107);
      burst(4'hd);
      chk("a0", a0, 1);
      chk("a1", a1, 0);
      chk("b0", b0, 1);
      chk("b1", b1, 1);
      chk("pipe r", pr, 1);
      chk("pipe f", pf, 1);
      bus(1, `OFS_CTRL, 32'h1107);
      q[0] = oe_n;
      @(posedge clk);
      chk("oe alt", oe_n, !q[0]);
      gsr_n <= 1'b0;
      cyc(6);
      chk("gsr a0", a0, 0);
      chk("gsr oe", oe_n, 1);
      gsr_n <= 1'b1;
      cyc(4);
      $display("gear end");
    end
  endtask
  ////////////////////////////////////////
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 6000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_sdr;
    t_ddr;
    t_delay;
    t_gear;
    complete_run;
  end
endmodule // ddr_input_capture_bench
